// ==== hw/dbt_defs.svh ====
// Register map, field positions, reset values and constants of the dual byte timer.
`ifndef DBT_DEFS_SVH
`define DBT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DBT_LOW_MATCH_ADDR 16'h7F10
`define DBT_HIGH_MATCH_ADDR 16'h7F11
`define DBT_CTRL_ADDR 16'h7F12
`define DBT_DIV_ADDR 16'h7F13

// ----------------------------------------------------------------------------
// Timer control bit positions
// ----------------------------------------------------------------------------
`define DBT_IE_BIT 0
`define DBT_FLG_BIT 1
`define DBT_RUN_BIT 2
`define DBT_CKS_LSB 3
`define DBT_CKS_MSB 4
`define DBT_SIE_BIT 5
`define DBT_SFLG_BIT 6
`define DBT_SSTS_BIT 7

// ----------------------------------------------------------------------------
// Divider control field positions
// ----------------------------------------------------------------------------
`define DBT_LIMIT_LSB 0
`define DBT_LIMIT_MSB 4
`define DBT_MODE_LSB 5
`define DBT_MODE_MSB 7

// ----------------------------------------------------------------------------
// Reset values and fixed constants
// ----------------------------------------------------------------------------
`define DBT_REG_RESET 8'h00
`define DBT_IRQ_VECTOR 16'h8008
`define DBT_BYTE_MAX 8'hFF

`endif

// ==== hw/dbt_pkg.sv ====
// Types shared by the dual byte timer.
package dbt_pkg;

	typedef enum logic [2:0] {
		DBT_MODE_T16 = 3'h0,
		DBT_MODE_TOG_PWM = 3'h1,
		DBT_MODE_PWM_STOP = 3'h2,
		DBT_MODE_TOG_STOP = 3'h3,
		DBT_MODE_TIM_PWM = 3'h4,
		DBT_MODE_TIM_TOG = 3'h5,
		DBT_MODE_PWM_PWM = 3'h6,
		DBT_MODE_TOG_TOG = 3'h7
	} dbt_mode_e;

	typedef enum logic [1:0] {
		DBT_CLK_SYS = 2'h0,
		DBT_CLK_RC = 2'h1,
		DBT_CLK_OSC_A = 2'h2,
		DBT_CLK_OSC_B = 2'h3
	} dbt_clk_e;

	// Writable part of the timer control register, bit 7 upward is derived.
	typedef struct packed {
		logic soft_irq_flag;
		logic soft_irq_enable;
		dbt_clk_e count_clock_select;
		logic run;
		logic match_flag;
		logic match_irq_enable;
	} dbt_ctrl_s;

	typedef struct packed {
		dbt_mode_e mode;
		logic [4:0] divider_limit;
	} dbt_div_s;

endpackage : dbt_pkg

// ==== hw/dbt_timer.sv ====
// Dual byte timer with divider, two waveform outputs and interrupt request.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "dbt_defs.svh"

module dbt_timer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Count clock sources from pins
	input wire logic rc_osc_in,
	input wire logic first_oscillator,
	input wire logic second_oscillator,
	// Outputs
	output logic low_wave_out,
	output logic high_wave_out,
	output logic irq_req,
	output logic [15:0] irq_vector
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [7:0] low_match_value_r;
	logic [7:0] high_match_value_r;
	dbt_pkg::dbt_ctrl_s timer_control_r;
	dbt_pkg::dbt_div_s divider_control_r;
	logic [7:0] low_buf_r;
	logic [7:0] high_buf_r;
	logic [4:0] div_cnt_r;
	logic [7:0] low_byte_counter_r;
	logic [7:0] high_byte_counter_r;
	logic [2:0] osc_s1_r;
	logic [2:0] osc_s2_r;
	logic [2:0] osc_s3_r;

	logic run;
	dbt_pkg::dbt_mode_e mode;
	logic soft_irq_status;
	logic count_tick;
	logic div_match;
	logic low_match;
	logic low_ovf;
	logic low_wrap;
	logic high_run;
	logic high_match;
	logic high_ovf;
	logic high_wrap;
	logic low_pwm;
	logic high_pwm;
	logic flag_set;
	logic [2:0] osc_rise;

	assign run = timer_control_r.run;
	assign mode = divider_control_r.mode;
	assign soft_irq_status = timer_control_r.soft_irq_flag & timer_control_r.soft_irq_enable;

	// ------------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------------
	// Mode 0 chains the two bytes into one 16-bit count.
	function automatic logic is_chained(input dbt_pkg::dbt_mode_e m);
		return m == dbt_pkg::DBT_MODE_T16;
	endfunction : is_chained

	// A PWM low byte free-runs 256 steps, so its period never depends on the match.
	function automatic logic low_is_pwm(input dbt_pkg::dbt_mode_e m);
		return (m == dbt_pkg::DBT_MODE_PWM_STOP) || (m == dbt_pkg::DBT_MODE_PWM_PWM);
	endfunction : low_is_pwm

	// The high byte runs as a 256-step PWM in these modes.
	function automatic logic high_is_pwm(input dbt_pkg::dbt_mode_e m);
		return (m == dbt_pkg::DBT_MODE_TOG_PWM) || (m == dbt_pkg::DBT_MODE_TIM_PWM) ||
			(m == dbt_pkg::DBT_MODE_PWM_PWM);
	endfunction : high_is_pwm

	// The high byte has no job in the two single-byte modes.
	// It stays parked at zero there, with its buffer following its register.
	function automatic logic high_is_parked(input dbt_pkg::dbt_mode_e m);
		return (m == dbt_pkg::DBT_MODE_PWM_STOP) || (m == dbt_pkg::DBT_MODE_TOG_STOP);
	endfunction : high_is_parked

	// Overflow is taken from the count value, so it is seen in the step before the wrap.
	function automatic logic byte_is_max(input logic [7:0] v);
		return v == `DBT_BYTE_MAX;
	endfunction : byte_is_max

	// One count step of a byte counter; past FF it wraps to zero by itself.
	function automatic logic [7:0] byte_step(input logic [7:0] v);
		return v + 8'h01;
	endfunction : byte_step

	// Addresses compare in full; a strobe to an unmapped address touches nothing.
	function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] target);
		return addr == target;
	endfunction : reg_hit

	// ------------------------------------------------------------------------
	// Count clock sources
	// ------------------------------------------------------------------------
	// Slow oscillators are sampled, never used as clocks, so every counter stays
	// in one domain; they must run below half the system clock rate.
	// A pin that is high when reset ends may be counted once; the timer is halted then.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			osc_s1_r <= 3'h0;
			osc_s2_r <= 3'h0;
			osc_s3_r <= 3'h0;
		end
		else
		begin
			osc_s1_r <= {second_oscillator, first_oscillator, rc_osc_in};
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	assign osc_rise = osc_s2_r & ~osc_s3_r;

	always_comb
	begin
		unique case (timer_control_r.count_clock_select)
			dbt_pkg::DBT_CLK_SYS: count_tick = 1'b1;
			dbt_pkg::DBT_CLK_RC: count_tick = osc_rise[0];
			dbt_pkg::DBT_CLK_OSC_A: count_tick = osc_rise[1];
			dbt_pkg::DBT_CLK_OSC_B: count_tick = osc_rise[2];
		endcase
	end

	// ------------------------------------------------------------------------
	// Event decode
	// ------------------------------------------------------------------------
	assign div_match = run && count_tick && (div_cnt_r == divider_control_r.divider_limit);

	// In mode 0 the low byte only clears on the full 16-bit match.
	assign low_match = div_match && (low_byte_counter_r == low_buf_r) &&
		(!is_chained(mode) || (high_byte_counter_r == high_buf_r));
	assign low_ovf = div_match && byte_is_max(low_byte_counter_r);
	assign low_pwm = low_is_pwm(mode);
	// PWM counters run a full 256 steps; the match only ends the high phase.
	assign low_wrap = low_pwm ? low_ovf : (low_match || (low_ovf && !is_chained(mode)));

	assign high_run = run && !high_is_parked(mode);
	assign high_pwm = high_is_pwm(mode);

	always_comb
	begin
		if (is_chained(mode))
		begin
			high_match = low_match;
			high_ovf = low_ovf && byte_is_max(high_byte_counter_r);
			high_wrap = low_match || high_ovf;
		end
		else
		begin
			high_match = high_run && (high_byte_counter_r == high_buf_r);
			high_ovf = high_run && byte_is_max(high_byte_counter_r);
			high_wrap = high_pwm ? high_ovf : (high_match || high_ovf);
		end
	end

	// The running timer's count turns to zero on each low byte period.
	assign flag_set = run && low_wrap;

	// ------------------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------------------
	// The divider restarts from zero on every start, so the first period is a full one.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !run)
			div_cnt_r <= 5'h00;
		else if (div_match)
			div_cnt_r <= 5'h00;
		else if (count_tick)
			div_cnt_r <= div_cnt_r + 5'h01;
	end

	// ------------------------------------------------------------------------
	// Low byte counter
	// ------------------------------------------------------------------------
	// In mode 0 the step past FF is the carry into the high byte, not a clear.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !run)
			low_byte_counter_r <= 8'h00;
		else if (low_wrap)
			low_byte_counter_r <= 8'h00;
		else if (div_match)
			low_byte_counter_r <= byte_step(low_byte_counter_r);
	end

	// ------------------------------------------------------------------------
	// High byte counter
	// ------------------------------------------------------------------------
	// Outside modes 0, 2 and 3 the high byte ignores the divider and counts system clocks.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !high_run)
			high_byte_counter_r <= 8'h00;
		else if (high_wrap)
			high_byte_counter_r <= 8'h00;
		else if (is_chained(mode))
		begin
			if (low_ovf)
				high_byte_counter_r <= byte_step(high_byte_counter_r);
		end
		else
			high_byte_counter_r <= byte_step(high_byte_counter_r);
	end

	// ------------------------------------------------------------------------
	// Match buffers
	// ------------------------------------------------------------------------
	// Reloading only on the wrap while running keeps one period from mixing an old and a new value.
	// Nothing here holds back a second write within a period on a slow count clock.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			low_buf_r <= `DBT_REG_RESET;
		else if (!run || low_wrap)
			low_buf_r <= low_match_value_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			high_buf_r <= `DBT_REG_RESET;
		else if (!high_run || high_wrap)
			high_buf_r <= high_match_value_r;
	end

	// ------------------------------------------------------------------------
	// Waveform outputs
	// ------------------------------------------------------------------------
	// With a PWM match of FF both edges fall in one cycle; the set wins, so a
	// full-scale setting gives a steady high level instead of a one-cycle dip.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !run)
			low_wave_out <= 1'b0;
		else
		begin
			unique case (mode)
				dbt_pkg::DBT_MODE_TOG_PWM, dbt_pkg::DBT_MODE_TOG_STOP, dbt_pkg::DBT_MODE_TOG_TOG:
					if (low_match)
						low_wave_out <= ~low_wave_out;
				dbt_pkg::DBT_MODE_PWM_STOP, dbt_pkg::DBT_MODE_PWM_PWM:
					if (low_ovf)
						low_wave_out <= 1'b1;
					else if (low_match)
						low_wave_out <= 1'b0;
				dbt_pkg::DBT_MODE_T16, dbt_pkg::DBT_MODE_TIM_PWM, dbt_pkg::DBT_MODE_TIM_TOG:
					low_wave_out <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !high_run)
			high_wave_out <= 1'b0;
		else
		begin
			unique case (mode)
				dbt_pkg::DBT_MODE_TIM_TOG, dbt_pkg::DBT_MODE_TOG_TOG:
					if (high_match)
						high_wave_out <= ~high_wave_out;
				dbt_pkg::DBT_MODE_TOG_PWM, dbt_pkg::DBT_MODE_TIM_PWM, dbt_pkg::DBT_MODE_PWM_PWM:
					if (high_ovf)
						high_wave_out <= 1'b1;
					else if (high_match)
						high_wave_out <= 1'b0;
				dbt_pkg::DBT_MODE_T16, dbt_pkg::DBT_MODE_PWM_STOP, dbt_pkg::DBT_MODE_TOG_STOP:
					high_wave_out <= 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	// Writes land at the edge that carries the strobe; the port never stalls.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			low_match_value_r <= `DBT_REG_RESET;
			high_match_value_r <= `DBT_REG_RESET;
			divider_control_r <= `DBT_REG_RESET;
		end
		else if (reg_wr)
		begin
			if (reg_hit(reg_addr, `DBT_LOW_MATCH_ADDR))
				low_match_value_r <= reg_wdata;
			if (reg_hit(reg_addr, `DBT_HIGH_MATCH_ADDR))
				high_match_value_r <= reg_wdata;
			if (reg_hit(reg_addr, `DBT_DIV_ADDR))
			begin
				divider_control_r.mode <= dbt_pkg::dbt_mode_e'(reg_wdata[`DBT_MODE_MSB:`DBT_MODE_LSB]);
				divider_control_r.divider_limit <= reg_wdata[`DBT_LIMIT_MSB:`DBT_LIMIT_LSB];
			end
		end
	end

	// Bit 7 is not stored, so a write there has no effect.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			timer_control_r <= 7'(`DBT_REG_RESET);
		else
		begin
			if (reg_wr && reg_hit(reg_addr, `DBT_CTRL_ADDR))
				timer_control_r <= reg_wdata[`DBT_SFLG_BIT:`DBT_IE_BIT];
			// A zero count arriving with a clearing write keeps the flag set.
			if (flag_set)
				timer_control_r.match_flag <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------------
	// Idle cycles return zero so that a stale value is never taken for an answer.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				`DBT_LOW_MATCH_ADDR: reg_rdata <= low_match_value_r;
				`DBT_HIGH_MATCH_ADDR: reg_rdata <= high_match_value_r;
				`DBT_CTRL_ADDR: reg_rdata <= {soft_irq_status, timer_control_r};
				`DBT_DIV_ADDR: reg_rdata <= divider_control_r;
				default: reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// ------------------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------------------
	// The request is registered, so it follows its cause by one cycle without glitches.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			irq_req <= 1'b0;
			irq_vector <= 16'h0000;
		end
		else
		begin
			irq_req <= (timer_control_r.match_irq_enable & timer_control_r.match_flag) |
				soft_irq_status;
			irq_vector <= `DBT_IRQ_VECTOR;
		end
	end

endmodule : dbt_timer

// ==== test/dbt_timer_assertions.sv ====
// Port checker of the dual byte timer, bound to the design top.
`timescale 1ns/1ps
`include "dbt_defs.svh"

module dbt_timer_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pins and outputs
	input wire logic rc_osc_in,
	input wire logic first_oscillator,
	input wire logic second_oscillator,
	input wire logic low_wave_out,
	input wire logic high_wave_out,
	input wire logic irq_req,
	input wire logic [15:0] irq_vector
);
	// ----------------------------
	// Shadow of software fields
	// ----------------------------
	logic [7:0] ctrl_r;
	logic [7:0] div_r;
	logic soft_on;
	logic irq_off;
	logic low_fixed;
	logic high_fixed;
	logic [7:0] ctrl_exp;
	assign soft_on = ctrl_r[6] & ctrl_r[5];
	assign irq_off = !ctrl_r[0] && !soft_on;
	assign low_fixed = !ctrl_r[2] || (div_r[7:5] inside {3'h0, 3'h4, 3'h5});
	assign high_fixed = !ctrl_r[2] || (div_r[7:5] inside {3'h0, 3'h2, 3'h3});
	// The flag bit is masked on readback because hardware sets it on its own.
	assign ctrl_exp = {soft_on, ctrl_r[6:2], 1'b0, ctrl_r[0]};

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ctrl_r <= 8'h00;
			div_r <= 8'h00;
		end
		else if (reg_wr && reg_addr == `DBT_CTRL_ADDR)
			ctrl_r <= reg_wdata;
		else if (reg_wr && reg_addr == `DBT_DIV_ADDR)
			div_r <= reg_wdata;
	end

	// ----------------------------
	// Assertions
	// ----------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	property p_rd_quiet;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet)
		else $error("read data outside its slot");
	property p_vector;
		!$past(sys_rst) |-> irq_vector == `DBT_IRQ_VECTOR;
	endproperty
	a_vector: assert property (p_vector)
		else $error("interrupt vector wrong");
	property p_ctrl_read;
		reg_rd && reg_addr == `DBT_CTRL_ADDR |=> (reg_rdata & 8'hFD) == $past(ctrl_exp);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("control readback wrong");
	property p_div_read;
		reg_rd && reg_addr == `DBT_DIV_ADDR |=> reg_rdata == $past(div_r);
	endproperty
	a_div_read: assert property (p_div_read)
		else $error("divider control readback wrong");
	property p_low_fixed;
		low_fixed && $past(low_fixed) |-> !low_wave_out;
	endproperty
	a_low_fixed: assert property (p_low_fixed)
		else $error("low wave not held low");
	property p_high_fixed;
		high_fixed && $past(high_fixed) |-> !high_wave_out;
	endproperty
	a_high_fixed: assert property (p_high_fixed)
		else $error("high wave not held low");
	property p_low_rise;
		$rose(low_wave_out) |-> !$past(low_fixed);
	endproperty
	a_low_rise: assert property (p_low_rise)
		else $error("low wave rose while fixed");
	property p_high_rise;
		$rose(high_wave_out) |-> !$past(high_fixed);
	endproperty
	a_high_rise: assert property (p_high_rise)
		else $error("high wave rose while fixed");
	property p_soft_irq;
		soft_on && $past(soft_on) |-> irq_req;
	endproperty
	a_soft_irq: assert property (p_soft_irq)
		else $error("software interrupt missing");
	property p_irq_quiet;
		irq_off && $past(irq_off) |-> !irq_req;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet)
		else $error("interrupt without enabled cause");

	c_soft: cover property (soft_on && irq_req);
	c_low: cover property ($rose(low_wave_out));
	c_high: cover property ($rose(high_wave_out));
endmodule : dbt_timer_checker

bind dbt_timer dbt_timer_checker u_dbt_timer_checker (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_osc_in(rc_osc_in),
	.first_oscillator(first_oscillator), .second_oscillator(second_oscillator),
	.low_wave_out(low_wave_out), .high_wave_out(high_wave_out), .irq_req(irq_req),
	.irq_vector(irq_vector)
);

// ==== test/test_dbt_timer.sv ====
// Self-checking bench of the dual byte timer.
`timescale 1ns/1ps
`include "dbt_defs.svh"

module test_dbt_timer;
	logic sys_clk, sys_rst, reg_wr, reg_rd;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic rc_osc_in = 1'b0;
	logic first_oscillator = 1'b0;
	logic second_oscillator = 1'b0;
	logic low_wave_out, high_wave_out, irq_req;
	logic [15:0] irq_vector, seed;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int ph = 0;

	dbt_timer u_dbt_timer (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rc_osc_in(rc_osc_in), .first_oscillator(first_oscillator),
		.second_oscillator(second_oscillator), .low_wave_out(low_wave_out),
		.high_wave_out(high_wave_out), .irq_req(irq_req), .irq_vector(irq_vector));

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Oscillator pins with periods of 6, 8 and 10 cycles, so a wrong select shows.
	always @(posedge sys_clk)
	begin
		ph <= ph + 1;
		rc_osc_in <= (ph % 6) < 3;
		first_oscillator <= (ph % 8) < 4;
		second_oscillator <= (ph % 10) < 5;
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			err_count++;
			final_report();
		end
	end

	// ----------------------------
	// Helpers
	// ----------------------------
	function automatic logic [7:0] next_rand();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction : next_rand

	function automatic int low_exp(input int md, input int m, input int l);
		return (md inside {0, 4, 5}) ? 0 : (m + 1) * (l + 1);
	endfunction : low_exp

	function automatic int high_exp(input int md, input int h);
		return (md inside {0, 2, 3}) ? 0 : h + 1;
	endfunction : high_exp

	function automatic logic wave(input bit hi);
		return hi ? high_wave_out : low_wave_out;
	endfunction : wave

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// An idle cycle follows each strobe so that no strobe is set twice in one step.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask : rd

	// Measures one whole high phase; a zero expectation means the output is fixed.
	task automatic expect_wave(input bit hi, input int exp);
		int n;
		logic prev;
		if (exp == 0)
		begin
			repeat (300) @(posedge sys_clk);
			check("fixed level", wave(hi), 1'b0);
			return;
		end
		prev = 1'b1;
		n = 0;
		while (!(prev === 1'b0 && wave(hi) === 1'b1) && n < 3000)
		begin
			prev = wave(hi);
			@(posedge sys_clk);
			n++;
		end
		n = 0;
		while (wave(hi) === 1'b1 && n < 3000)
		begin
			@(posedge sys_clk);
			n++;
		end
		check("high phase", n, exp);
	endtask : expect_wave

	// ----------------------------
	// Main sequence
	// ----------------------------
	initial
	begin
		logic [7:0] d;
		logic [7:0] r;
		int m;
		int l;
		int h;
		sys_rst = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		seed = 16'h60CE;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		for (int a = 16'h7F10; a <= 16'h7F14; a++)
		begin
			rd(16'(a), r);
			check("reset value", r, 8'h00);
		end
		check("vector", irq_vector, `DBT_IRQ_VECTOR);
		for (int a = 16'h7F10; a <= 16'h7F14; a++)
		begin
			if (a == `DBT_CTRL_ADDR)
				continue;
			d = next_rand();
			wr(16'(a), d);
			rd(16'(a), r);
			check("readback", r, (a == 16'h7F14) ? 8'h00 : d);
		end
		for (int md = 1; md < 8; md++)
		begin
			l = next_rand() % 4;
			m = 1 + next_rand() % 8;
			h = 1 + next_rand() % 64;
			wr(`DBT_CTRL_ADDR, 8'h00);
			wr(`DBT_LOW_MATCH_ADDR, 8'(m));
			wr(`DBT_HIGH_MATCH_ADDR, 8'(h));
			wr(`DBT_DIV_ADDR, {3'(md), 5'(l)});
			wr(`DBT_CTRL_ADDR, 8'h04);
			expect_wave(1'b0, low_exp(md, m, l));
			expect_wave(1'b1, high_exp(md, h));
		end
		// Mode 7 is still running: a new low match must take effect after a reload.
		m = 1 + next_rand() % 8;
		wr(`DBT_LOW_MATCH_ADDR, 8'(m));
		expect_wave(1'b0, low_exp(7, m, l));
		expect_wave(1'b0, low_exp(7, m, l));
		wr(`DBT_CTRL_ADDR, 8'h00);
		wr(`DBT_LOW_MATCH_ADDR, 8'h01);
		wr(`DBT_DIV_ADDR, 8'h60);
		for (int s = 0; s < 4; s++)
		begin
			wr(`DBT_CTRL_ADDR, 8'h00);
			wr(`DBT_CTRL_ADDR, 8'(4 | (s << 3)));
			expect_wave(1'b0, 2 * ((s == 0) ? 1 : 4 + 2 * s));
		end
		wr(`DBT_CTRL_ADDR, 8'h05);
		repeat (20) @(posedge sys_clk);
		rd(`DBT_CTRL_ADDR, r);
		check("flag set", r, 8'h07);
		check("match irq", irq_req, 1'b1);
		wr(`DBT_CTRL_ADDR, 8'h03);
		rd(`DBT_CTRL_ADDR, r);
		check("flag kept", r, 8'h03);
		wr(`DBT_CTRL_ADDR, 8'h01);
		rd(`DBT_CTRL_ADDR, r);
		check("flag cleared", r, 8'h01);
		check("irq cleared", irq_req, 1'b0);
		// Mode 0 chains both bytes: the flag waits for the full 16-bit count of 289.
		wr(`DBT_LOW_MATCH_ADDR, 8'h20);
		wr(`DBT_HIGH_MATCH_ADDR, 8'h01);
		wr(`DBT_DIV_ADDR, 8'h00);
		wr(`DBT_CTRL_ADDR, 8'h05);
		repeat (250) @(posedge sys_clk);
		rd(`DBT_CTRL_ADDR, r);
		check("chain early", r, 8'h05);
		repeat (40) @(posedge sys_clk);
		rd(`DBT_CTRL_ADDR, r);
		check("chain flag", r, 8'h07);
		wr(`DBT_CTRL_ADDR, 8'h00);
		wr(`DBT_CTRL_ADDR, 8'hE0);
		rd(`DBT_CTRL_ADDR, r);
		check("soft status", r, 8'hE0);
		check("soft irq", irq_req, 1'b1);
		wr(`DBT_CTRL_ADDR, 8'h40);
		rd(`DBT_CTRL_ADDR, r);
		check("soft masked", r, 8'h40);
		check("soft irq off", irq_req, 1'b0);
		final_report();
	end
endmodule : test_dbt_timer
